// *** hdl/phy_id_autoneg_ability_regs.sv ***
// Identifier and auto-negotiation ability registers behind the management interface
//
// Behaviour
// - Identifier low register bits 9:4 read back the fixed six-bit model number.
// - Identifier low register bits 3:0 read back the fixed four-bit revision number.
// - Advertisement bit 15 is a writable next-page request, cleared at reset.
// - Advertisement bit 13 is a writable remote-fault flag, cleared at reset.
// - Advertisement bits 11 and 10 are writable pause abilities, cleared at reset.
// - Advertisement bit 9 always reads zero and ignores writes.
// - Advertisement bits 8 to 5 are writable abilities, set at reset then taken from straps.
// - Advertisement bits 4:0 are a writable selector that resets to 00001.
// - Partner bit 15 shows the partner's next-page request.
// - Partner bit 14 shows the partner's acknowledge.
// - Partner bit 13 shows the partner's remote fault.
// - Partner bits 11 and 10 show the partner's pause abilities.
// - Partner bits 9 to 5 mirror the partner's technology abilities and clear at reset.
// - Partner bits 4:0 copy the partner's selector and reset to zero.
`timescale 1ns/100ps
`include "phy_regs_defines.svh"
module phy_id_autoneg_ability_regs
	import phy_regs_pkg::*;
#(
	parameter int PHY_ADDR = 1,
	parameter int OUI_HIGH = 16'h1234, // Arbitrary identity value
	parameter int OUI_LOW = 6'h15, // Arbitrary identity value
	parameter int MODEL = 6'h2a, // Arbitrary identity value
	parameter int REV = 4'h3 // Arbitrary identity value
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic [3:0] strap_adv,
	input wire lcw_page_s page_rx,
	output logic [15:0] advert_word
);
	// ==========================================================
	// Parameter checks
	generate
		if (PHY_ADDR < 0 || PHY_ADDR > 31) begin : g_bad_addr
			$error("PHY_ADDR must fit five bits");
		end
		if (OUI_HIGH < 0 || OUI_HIGH > 16'hffff || OUI_LOW < 0 || OUI_LOW > 6'h3f) begin : g_bad_oui
			$error("identifier fields out of range");
		end
		if (MODEL < 0 || MODEL > 6'h3f || REV < 0 || REV > 4'hf) begin : g_bad_model
			$error("model or revision out of range");
		end
	endgenerate

	localparam logic [4:0] PHY_ADDR_L = 5'(PHY_ADDR);
	localparam logic [15:0] OUI_HIGH_L = 16'(OUI_HIGH);
	localparam logic [5:0] OUI_LOW_L = 6'(OUI_LOW);
	localparam logic [5:0] MODEL_L = 6'(MODEL);
	localparam logic [3:0] REV_L = 4'(REV);

	// ==========================================================
	// Pin synchronisers
	logic [5:0] pins_s;
	logic mdc_s;
	logic mdio_s;
	logic [3:0] strap_s;

	sync2 #(
		.WIDTH(6)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({strap_adv, mdio_in, mdc}),
		.sync_out(pins_s)
	);

	assign mdc_s = pins_s[0];
	assign mdio_s = pins_s[1];
	assign strap_s = pins_s[5:2];

	// ==========================================================
	// Partner ability register
	logic [15:0] partner_word;

	lp_capture u_lp_capture (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.page_in(page_rx),
		.partner_word(partner_word)
	);

	// ==========================================================
	// State
	regs_state_s s_q;
	regs_state_s s_d;
	logic mdc_rise;
	logic [11:0] hdr_next;
	logic [15:0] wr_word;
	logic wr_adv;
	logic [15:0] rd_word;
	logic [15:0] exp_word;

	// Edge found after the synchroniser, so a bit lands three clocks after the pin
	assign mdc_rise = mdc_s && !s_q.mdc_prev;
	assign hdr_next = {s_q.hdr[10:0], mdio_s};
	assign wr_word = {s_q.sh[14:0], mdio_s};
	assign wr_adv = mdc_rise && (s_q.fsm == st_write) && (s_q.cnt == `MDIO_DATA_LAST)
		&& (s_q.hdr[4:0] == `REG_ADVERT);

	always_comb begin
		exp_word = '0;
		exp_word[`EXP_LOCAL_NP] = 1'b1;
		exp_word[`EXP_PAGE_RX] = s_q.page_rx;
	end

	// ==========================================================
	// Read mux; unmapped offsets read zero
	always_comb begin
		unique case (s_q.hdr[4:0])
			`REG_IDENT_HIGH: rd_word = OUI_HIGH_L;
			`REG_IDENT_LOW: rd_word = {OUI_LOW_L, MODEL_L, REV_L};
			`REG_ADVERT: rd_word = s_q.advert;
			`REG_PARTNER: rd_word = partner_word;
			`REG_EXPANSION: rd_word = exp_word;
			default: rd_word = 16'h0000;
		endcase
	end

	// ==========================================================
	// Management frame engine and register updates
	always_comb begin
		s_d = s_q;
		s_d.mdc_prev = mdc_s;
		// Straps read only once the synchroniser has filled after release
		if (s_q.strap_cnt != `STRAP_DONE) begin
			s_d.strap_cnt = s_q.strap_cnt + 2'h1;
			if (s_q.strap_cnt == `STRAP_SETTLE) begin
				s_d.advert[`ADV_ABIL_HI:`ADV_ABIL_LO] = strap_s;
			end
		end
		if (mdc_rise) begin
			unique case (s_q.fsm)
				st_idle: begin
					if (!mdio_s) begin
						s_d.fsm = st_start;
					end
				end
				st_start: begin
					s_d.cnt = 5'h00;
					s_d.fsm = mdio_s ? st_hdr : st_idle;
				end
				st_hdr: begin
					s_d.hdr = hdr_next;
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == `MDIO_HDR_LAST) begin
						s_d.cnt = 5'h00;
						if (hdr_next[9:5] != PHY_ADDR_L) begin
							s_d.fsm = st_skip;
						end else if (hdr_next[11:10] == `MDIO_OP_READ) begin
							s_d.fsm = st_turn;
						end else if (hdr_next[11:10] == `MDIO_OP_WRITE) begin
							s_d.fsm = st_wturn;
						end else begin
							s_d.fsm = st_skip;
						end
					end
				end
				st_turn: begin
					// Drive the second turnaround bit low, then data
					s_d.mdio_oe_n = 1'b0;
					s_d.mdio_out = 1'b0;
					s_d.sh = rd_word;
					s_d.cnt = 5'h00;
					s_d.fsm = st_read;
					if (s_q.hdr[4:0] == `REG_EXPANSION) begin
						s_d.page_rx = 1'b0;
					end
				end
				st_read: begin
					if (s_q.cnt == `MDIO_DATA_BITS) begin
						// Let go after the last bit so the host owns the next frame
						s_d.mdio_oe_n = 1'b1;
						s_d.mdio_out = 1'b0;
						s_d.fsm = st_idle;
					end else begin
						s_d.mdio_out = s_q.sh[15];
						s_d.sh = {s_q.sh[14:0], 1'b0};
						s_d.cnt = s_q.cnt + 5'h01;
					end
				end
				st_wturn: begin
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == `MDIO_TA_LAST) begin
						s_d.cnt = 5'h00;
						s_d.fsm = st_write;
					end
				end
				st_write: begin
					s_d.sh = wr_word;
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == `MDIO_DATA_LAST) begin
						s_d.fsm = st_idle;
						if (s_q.hdr[4:0] == `REG_ADVERT) begin
							// Read-only and reserved bits keep their value
							s_d.advert = (s_q.advert & ~`ADV_WR_MASK)
								| (wr_word & `ADV_WR_MASK);
							s_d.advert[`ADV_NEXT_PAGE] = wr_word[`ADV_NEXT_PAGE];
							s_d.advert[`ADV_REMOTE_FAULT] = wr_word[`ADV_REMOTE_FAULT];
							s_d.advert[`ADV_ASYM_PAUSE] = wr_word[`ADV_ASYM_PAUSE];
							s_d.advert[`ADV_PAUSE] = wr_word[`ADV_PAUSE];
							s_d.advert[`ADV_T4] = 1'b0;
							s_d.advert[4:0] = wr_word[4:0];
							s_d.adv_written = 1'b1;
						end
					end
				end
				st_skip: begin
					// Other address or bad opcode: let the frame pass
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == `MDIO_SKIP_LAST) begin
						s_d.cnt = 5'h00;
						s_d.fsm = st_idle;
					end
				end
			endcase
		end
		// A page landing with the read still counts
		if (page_rx.valid) begin
			s_d.page_rx = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q.fsm <= st_idle;
			s_q.cnt <= 5'h00;
			s_q.hdr <= 12'h000;
			s_q.sh <= 16'h0000;
			s_q.mdc_prev <= 1'b0;
			s_q.mdio_out <= 1'b0;
			s_q.mdio_oe_n <= 1'b1;
			s_q.advert <= `ADV_RESET;
			s_q.page_rx <= 1'b0;
			s_q.strap_cnt <= 2'h0;
			s_q.adv_written <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign mdio_out = s_q.mdio_out;
	assign mdio_oe_n = s_q.mdio_oe_n;
	assign advert_word = s_q.advert;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_read_turn;
		mdc_rise && (s_q.fsm == st_turn);
	endsequence

	sequence s_read_end;
		mdc_rise && (s_q.fsm == st_read) && (s_q.cnt == `MDIO_DATA_BITS);
	endsequence

	a_model_field: assert property ((s_q.hdr[4:0] == `REG_IDENT_LOW) |->
		rd_word[9:4] == MODEL_L)
		else $error("model number field wrong");
	a_rev_field: assert property ((s_q.hdr[4:0] == `REG_IDENT_LOW) |->
		rd_word[3:0] == REV_L && rd_word[15:10] == OUI_LOW_L)
		else $error("revision field wrong");
	a_np_write: assert property (wr_adv |=>
		advert_word[`ADV_NEXT_PAGE] == $past(wr_word[`ADV_NEXT_PAGE]))
		else $error("next page bit not written");
	a_fault_write: assert property (wr_adv |=>
		advert_word[`ADV_REMOTE_FAULT] == $past(wr_word[`ADV_REMOTE_FAULT]))
		else $error("remote fault bit not written");
	a_pause_write: assert property (wr_adv |=>
		advert_word[11:10] == $past(wr_word[11:10]) && advert_word[4:0] == $past(wr_word[4:0]))
		else $error("pause or selector not written");
	a_t4_zero: assert property (advert_word[`ADV_T4] == 1'b0)
		else $error("four-pair ability advertised");
	a_adv_rsvd: assert property (advert_word[14] == 1'b0 && advert_word[12] == 1'b0)
		else $error("reserved advertisement bit set");
	a_strap_load: assert property ((s_q.strap_cnt == `STRAP_SETTLE && !wr_adv) |=>
		advert_word[`ADV_ABIL_HI:`ADV_ABIL_LO] == $past(strap_s))
		else $error("straps not applied");
	a_sel_default: assert property (!s_q.adv_written |->
		advert_word[4:0] == `SEL_IEEE && advert_word[15] == 1'b0)
		else $error("selector default wrong");
	a_read_drive: assert property (s_read_turn |=> !mdio_oe_n && !mdio_out && s_q.sh == $past(rd_word))
		else $error("turnaround not driven low");
	a_read_release: assert property (s_read_end |=> mdio_oe_n ##1 (s_q.fsm != st_read))
		else $error("bus not released after data");

	// ==========================================================
	// Frame and flag checks
	sequence s_write_last;
		wr_adv;
	endsequence

	sequence s_foreign_write;
		mdc_rise && (s_q.fsm == st_write) && (s_q.cnt == `MDIO_DATA_LAST)
			&& (s_q.hdr[4:0] != `REG_ADVERT);
	endsequence

	sequence s_exp_read;
		mdc_rise && (s_q.fsm == st_turn) && (s_q.hdr[4:0] == `REG_EXPANSION);
	endsequence

	sequence s_skip_end;
		mdc_rise && (s_q.fsm == st_skip) && (s_q.cnt == `MDIO_SKIP_LAST);
	endsequence

	sequence s_page_seen;
		page_rx.valid;
	endsequence

	a_abil_write: assert property (s_write_last |=>
		advert_word[`ADV_ABIL_HI:`ADV_ABIL_LO] == $past(wr_word[`ADV_ABIL_HI:`ADV_ABIL_LO]))
		else $error("ability bits not written");
	a_adv_steady: assert property ((s_q.strap_cnt == `STRAP_DONE && !wr_adv) |=>
		$stable(advert_word))
		else $error("advertisement changed without a write");
	a_foreign_write: assert property (s_foreign_write |=> $stable(advert_word))
		else $error("write to another register took effect");
	// Two drivers on the data line would fight, so drive only in the read phase
	a_drive_window: assert property (mdio_oe_n == (s_q.fsm != st_read))
		else $error("data line driven outside the read phase");
	a_skip_quiet: assert property (s_skip_end |=> (s_q.fsm == st_idle) && mdio_oe_n)
		else $error("foreign frame not passed over");
	a_page_flag: assert property (s_page_seen |=> s_q.page_rx)
		else $error("page received flag not set");
	a_exp_clear: assert property (s_exp_read |=> s_q.page_rx == $past(page_rx.valid))
		else $error("page received flag not cleared by read");
	a_ident_high: assert property ((s_q.hdr[4:0] == `REG_IDENT_HIGH) |->
		rd_word == OUI_HIGH_L)
		else $error("identifier high word wrong");
	a_partner_view: assert property ((s_q.hdr[4:0] == `REG_PARTNER) |->
		rd_word == partner_word)
		else $error("partner word not on read path");
	a_unmapped_zero: assert property ((s_q.hdr[4:0] > `REG_EXPANSION
		|| s_q.hdr[4:0] < `REG_IDENT_HIGH) |-> rd_word == 16'h0000)
		else $error("unmapped offset read nonzero");
endmodule

// *** hdl/phy_regs_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the register bank
`ifndef PHY_REGS_DEFINES_SVH
`define PHY_REGS_DEFINES_SVH

// ==========================================================
// Register offsets on the management bus
`define REG_IDENT_HIGH 5'h02
`define REG_IDENT_LOW 5'h03
`define REG_ADVERT 5'h04
`define REG_PARTNER 5'h05
`define REG_EXPANSION 5'h06

// ==========================================================
// Advertisement fields
`define ADV_NEXT_PAGE 15
`define ADV_REMOTE_FAULT 13
`define ADV_ASYM_PAUSE 11
`define ADV_PAUSE 10
`define ADV_T4 9
`define ADV_ABIL_HI 8
`define ADV_ABIL_LO 5
`define ADV_WR_MASK 16'hadff
`define ADV_RESET 16'h01e1
`define SEL_IEEE 5'h01

// ==========================================================
// Expansion fields
`define EXP_LOCAL_NP 2
`define EXP_PAGE_RX 1

// ==========================================================
// Partner ability: bit 12 reserved
`define LP_MASK 16'hefff

// ==========================================================
// Management frame
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_HDR_LAST 5'h0b
`define MDIO_TA_LAST 5'h01
`define MDIO_DATA_BITS 5'h10
`define MDIO_DATA_LAST 5'h0f
`define MDIO_SKIP_LAST 5'h11

// ==========================================================
// Strap capture after reset release
`define STRAP_SETTLE 2'h2
`define STRAP_DONE 2'h3

`endif

// *** hdl/phy_regs_pkg.sv ***
// Types shared by the management register bank
package phy_regs_pkg;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_start = 3'b001,
		st_hdr = 3'b010,
		st_turn = 3'b011,
		st_read = 3'b100,
		st_wturn = 3'b101,
		st_write = 3'b110,
		st_skip = 3'b111
	} mdio_state_e;

	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} lcw_page_s;

	typedef struct packed {
		mdio_state_e fsm;
		logic [4:0] cnt;
		logic [11:0] hdr;
		logic [15:0] sh;
		logic mdc_prev;
		logic mdio_out;
		logic mdio_oe_n;
		logic [15:0] advert;
		logic page_rx;
		logic [1:0] strap_cnt;
		logic adv_written;
	} regs_state_s;

	typedef struct packed {
		logic [15:0] word;
	} partner_state_s;

endpackage

// *** hdl/sync2.sv ***
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [1:0][WIDTH-1:0] stage_q;
	logic [1:0][WIDTH-1:0] stage_d;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("sync2 needs WIDTH of at least 1");
		end
	endgenerate

	// First stage feeds only the second
	always_comb begin
		stage_d[0] = async_in;
		stage_d[1] = stage_q[0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= '0;
		end else begin
			stage_q <= stage_d;
		end
	end

	assign sync_out = stage_q[1];
endmodule

// *** hdl/lp_capture.sv ***
// Partner ability word, loaded from each received base page
`timescale 1ns/100ps
`include "phy_regs_defines.svh"
module lp_capture
	import phy_regs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire lcw_page_s page_in,
	output logic [15:0] partner_word
);
	partner_state_s s_q;
	partner_state_s s_d;

	always_comb begin
		s_d = s_q;
		if (page_in.valid) begin
			s_d.word[15] = page_in.word[15];
			s_d.word[14] = page_in.word[14];
			s_d.word[13] = page_in.word[13];
			s_d.word[12] = 1'b0;
			s_d.word[11:10] = page_in.word[11:10];
			s_d.word[9:5] = page_in.word[9:5];
			s_d.word[4:0] = page_in.word[4:0];
		end
	end

	// Cleared at reset so software never sees a stale partner
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign partner_word = s_q.word;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_partner_load: assert property (page_in.valid |=>
		partner_word == ($past(page_in.word) & `LP_MASK))
		else $error("partner word not loaded from page");
	a_partner_hold: assert property (!page_in.valid |=> $stable(partner_word))
		else $error("partner word changed without a page");
	a_partner_rsvd: assert property (partner_word[12] == 1'b0)
		else $error("partner reserved bit set");
endmodule

// *** dv/mgmt_master_model.sv ***
// Station management controller model driving frames onto the shared data line
`timescale 1ns/100ps
module mgmt_master_model (
	input wire logic clk_sys,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	output logic mdc,
	output logic mdio_line
);
	logic drv_oe = 1'b0;
	logic drv_bit = 1'b1;

	initial mdc = 1'b0;

	// ==========================================================
	// Wire level
	// Pull-up holds the line high once both parties let go
	assign mdio_line = !mdio_oe_n ? mdio_out : (drv_oe ? drv_bit : 1'b1);

	// ==========================================================
	// Frame
	// Clock stands low between frames; five clocks per phase keeps mdc under the limit
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [33:0] bits;
		logic [33:0] oe;
		bits = {4'hd, op, pa, ra, 2'h2, wd};
		oe = (op == 2'h2) ? {16'hffff, 18'h00000} : 34'h3ffffffff;
		rd = 16'h0000;
		for (int i = 33; i >= 0; i--) begin
			drv_oe = oe[i];
			drv_bit = bits[i];
			mdc = 1'b0;
			repeat (5) @(posedge clk_sys);
			#1 mdc = 1'b1;
			if (i < 16) begin
				rd[i] = mdio_line;
			end
			repeat (5) @(posedge clk_sys);
			#1;
		end
		mdc = 1'b0;
		drv_oe = 1'b0;
		// One idle clock so a following frame never reassigns in this step
		@(posedge clk_sys);
		#1;
	endtask
endmodule

// *** dv/phy_id_autoneg_ability_regs_tb.sv ***
// Self-checking bench for the identifier and ability register bank
`timescale 1ns/100ps
`include "phy_regs_defines.svh"
module phy_id_autoneg_ability_regs_tb
	import phy_regs_pkg::*;
;
	localparam logic [15:0] OUI_HI = 16'h1234; // Arbitrary identity value
	localparam logic [5:0] OUI_LO = 6'h15; // Arbitrary identity value
	localparam logic [5:0] MODEL_NO = 6'h2a; // Arbitrary identity value
	localparam logic [3:0] REV_NO = 4'h3; // Arbitrary identity value
	localparam logic [4:0] PHY_AD = 5'h01;

	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] strap_adv = 4'ha;
	lcw_page_s page_rx = '0;
	logic mdc;
	logic mdio_line;
	logic mdio_out;
	logic mdio_oe_n;
	logic [15:0] advert_word;
	logic [15:0] rd;
	int error_cnt = 0;
	int compares = 0;

	always #25 clk_sys = ~clk_sys;

	phy_id_autoneg_ability_regs #(.PHY_ADDR(1), .OUI_HIGH(OUI_HI), .OUI_LOW(OUI_LO),
		.MODEL(MODEL_NO), .REV(REV_NO)) phy_id_autoneg_ability_regs_inst (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.mdc(mdc),
		.mdio_in(mdio_line),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.strap_adv(strap_adv),
		.page_rx(page_rx),
		.advert_word(advert_word)
	);

	mgmt_master_model mgmt_master_model_inst (
		.clk_sys(clk_sys),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.mdc(mdc),
		.mdio_line(mdio_line)
	);

	// ==========================================================
	// Helpers
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
		mgmt_master_model_inst.frame(`MDIO_OP_READ, PHY_AD, ra, 16'h0000, d);
	endtask

	task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] dummy;
		mgmt_master_model_inst.frame(`MDIO_OP_WRITE, PHY_AD, ra, d, dummy);
		@(posedge clk_sys);
		#1;
	endtask

	task automatic send_page(input logic [15:0] w);
		@(posedge clk_sys);
		#1 page_rx = '{valid: 1'b1, word: w};
		@(posedge clk_sys);
		#1 page_rx.valid = 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	// Straps 1010 leave 100 full and 10 full advertised
	task automatic t_defaults();
		chk16(advert_word, 16'h0141);
		rd_reg(`REG_ADVERT, rd);
		chk16(rd, 16'h0141);
		rd_reg(`REG_PARTNER, rd);
		chk16(rd, 16'h0000);
		rd_reg(`REG_EXPANSION, rd);
		chk16(rd, 16'h0004);
	endtask

	task automatic t_ident();
		rd_reg(`REG_IDENT_HIGH, rd);
		chk16(rd, OUI_HI);
		rd_reg(`REG_IDENT_LOW, rd);
		chk16(rd, {OUI_LO, MODEL_NO, REV_NO});
	endtask

	// Reserved and fixed bits must survive an all-ones write
	task automatic t_adv_write();
		wr_reg(`REG_ADVERT, 16'hffff);
		chk16(advert_word, 16'hadff);
		rd_reg(`REG_ADVERT, rd);
		chk16(rd, 16'hadff);
		wr_reg(`REG_ADVERT, 16'h0000);
		chk16(advert_word, 16'h0000);
		wr_reg(`REG_IDENT_LOW, 16'h0000);
		rd_reg(`REG_IDENT_LOW, rd);
		chk16(rd, {OUI_LO, MODEL_NO, REV_NO});
	endtask

	task automatic t_partner();
		send_page(16'hffff);
		rd_reg(`REG_PARTNER, rd);
		chk16(rd, 16'hefff);
		rd_reg(`REG_EXPANSION, rd);
		chk16(rd, 16'h0006);
		rd_reg(`REG_EXPANSION, rd);
		chk16(rd, 16'h0004);
		send_page(16'h4021);
		rd_reg(`REG_PARTNER, rd);
		chk16(rd, 16'h4021);
		wr_reg(`REG_PARTNER, 16'h0000);
		rd_reg(`REG_PARTNER, rd);
		chk16(rd, 16'h4021);
	endtask

	// Foreign address or bad opcode is passed over; unmapped offset reads zero
	task automatic t_refused();
		mgmt_master_model_inst.frame(`MDIO_OP_READ, 5'h02, `REG_ADVERT, 16'h0000, rd);
		chk16(rd, 16'hffff);
		rd_reg(5'h1f, rd);
		chk16(rd, 16'h0000);
		mgmt_master_model_inst.frame(`MDIO_OP_WRITE, 5'h02, `REG_ADVERT, 16'hffff, rd);
		chk16(advert_word, 16'h0000);
		mgmt_master_model_inst.frame(2'h3, PHY_AD, `REG_ADVERT, 16'hffff, rd);
		chk16(advert_word, 16'h0000);
	endtask

	// Reset in mid-run with new straps 0101: only 100 half and 10 half advertised
	task automatic t_reset_mid();
		@(posedge clk_sys);
		#1 rst_n = 1'b0;
		strap_adv = 4'h5;
		@(posedge clk_sys);
		#1;
		chk16(advert_word, `ADV_RESET);
		chk16({15'h0000, mdio_oe_n}, 16'h0001);
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		chk16(advert_word, 16'h00a1);
		rd_reg(`REG_PARTNER, rd);
		chk16(rd, 16'h0000);
		rd_reg(`REG_EXPANSION, rd);
		chk16(rd, 16'h0004);
	endtask

	// ==========================================================
	// Run control
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		t_defaults();
		t_ident();
		t_adv_write();
		t_partner();
		t_refused();
		t_reset_mid();
		print_verdict();
	end

	// About 22 frames of 350 clocks; limit leaves wide margin
	initial begin
		#1000000;
		error_cnt++;
		print_verdict();
	end
endmodule
